// ---- hw/eas_host.sv ----
// What this block does
// - wait power-stable interval before first access of any kind.
// - address held stable through address-to-write-end before write end.
// - write strobe never starts before address is valid.
// - address kept valid until write-ending edge has passed.
// - data valid for data-setup interval before the write end.
// - byte selects held active long enough before write end.
// - write only while strobe, select and a lane are all low.
// - write strobe edge ends the write; timing counted from it.
// - strobe with enable high lasts float time plus byte-select-to-write-end.
// - host waits for memory release before driving write data.
// - write strobe stays high throughout every read.
// - address valid before or with chip select in reads.
`default_nettype none
module eas_host
   import eas_pkg::*;
#(
   parameter int POWER_WAIT = POWER_CYC
) (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rstn,
   // user request side
   input  wire logic              reqValid,
   input  wire eas_req_s          req,
   output logic                   reqReady,
   output logic                   rspValid,
   output eas_rsp_s               rsp,
   // memory address and controls
   output logic [ADDR_W-1:0]      memAddr,
   output logic                   select_low_active,
   output logic                   select_high_active,
   output logic                   memOeN,
   output logic                   memWeN,
   output logic                   upper_byte_sel_n,
   output logic                   lower_byte_sel_n,
   // memory data pins
   input  wire logic [DATA_W-1:0] memDataIn,
   output logic [DATA_W-1:0]      memDataOut,
   output logic [DATA_W-1:0]      memDataOen,
   input  wire logic              memErrIn
);
   typedef enum logic [2:0] {
      ST_POWER, ST_IDLE, ST_READ, ST_TURN, ST_WSETUP, ST_WRITE,
      ST_WEND, ST_REL
   } eas_state_e;

   eas_state_e        state_q;
   logic [CNT_W-1:0]  cnt_q;
   logic [DATA_W-1:0] dataSync;
   logic              errSync;
   logic [LANES-1:0]  lanes_q;
   logic              write_q;

   // ==========================================================
   // pin inputs are from the memory, synchronise them
   eas_sync #(
      .W (DATA_W + 1)
   ) u_sync (
      .sys_clk (sys_clk),
      .rstn    (rstn),
      .asyncIn ({memErrIn, memDataIn}),
      .syncOut ({errSync, dataSync})
   );

   // ==========================================================
   // sequencer
   // read: select+enable, wait access time plus sync delay, sample
   // write: release bus, then drive data, strobe, end with strobe
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= ST_POWER;
         cnt_q   <= '0;
      end else begin
         case (state_q)
            ST_POWER: begin
               if (cnt_q == CNT_W'(POWER_WAIT - 1)) begin
                  state_q <= ST_IDLE;
                  cnt_q   <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            ST_IDLE: begin
               cnt_q <= '0;
               if (reqValid && reqReady) begin
                  // bus was released in idle, so writes may drive
                  state_q <= req.write ? ST_WSETUP : ST_READ;
               end
            end
            ST_READ: begin
               // pins lag one cycle, then access, then two sync stages
               if (cnt_q == CNT_W'(READ_CYC + 2)) begin
                  state_q <= ST_REL;
                  cnt_q   <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            ST_WSETUP: begin
               state_q <= ST_WRITE; // address settles before strobe
               cnt_q   <= '0;
            end
            ST_WRITE: begin
               if (cnt_q == CNT_W'(WRITE_CYC - 1)) begin
                  state_q <= ST_WEND;
                  cnt_q   <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            ST_WEND: begin
               state_q <= ST_REL; // hold address past write end
               cnt_q   <= '0;
            end
            ST_REL: begin
               // memory float time before the next access
               if (cnt_q == CNT_W'(TURN_CYC - 1)) begin
                  state_q <= ST_IDLE;
                  cnt_q   <= '0;
               end else begin
                  cnt_q <= cnt_q + 1'b1;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               cnt_q   <= '0;
            end
         endcase
      end
   end

   // ==========================================================
   // request capture: address, data and lanes latched once
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         memAddr    <= '0;
         memDataOut <= '0;
         lanes_q    <= '0;
         write_q    <= 1'b0;
      end else if (state_q == ST_IDLE && reqValid && reqReady) begin
         memAddr    <= req.addr; // stable until release
         memDataOut <= req.wdata;
         lanes_q    <= req.lanes;
         write_q    <= req.write;
      end
   end

   // ==========================================================
   // control pins, registered from the current state, one cycle behind it
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         select_low_active  <= 1'b1;
         select_high_active <= 1'b0;
         memOeN             <= 1'b1;
         memWeN             <= 1'b1;
         upper_byte_sel_n   <= 1'b1;
         lower_byte_sel_n   <= 1'b1;
      end else begin
         // select low and second select high only during access
         if (state_q == ST_READ || state_q == ST_WRITE) begin
            select_low_active  <= 1'b0;
            select_high_active <= 1'b1;
            lower_byte_sel_n   <= ~lanes_q[0];
            upper_byte_sel_n   <= ~lanes_q[1];
         end else begin
            select_low_active  <= 1'b1; // deselect to standby
            select_high_active <= 1'b0;
            lower_byte_sel_n   <= 1'b1;
            upper_byte_sel_n   <= 1'b1;
         end
         memOeN <= !(state_q == ST_READ);
         // strobe only in writes, never in reads
         memWeN <= !(state_q == ST_WRITE && write_q);
      end
   end

   // ==========================================================
   // data drive enables, low while driving, per lane
   genvar b;
   generate
      for (b = 0; b < LANES; b++) begin : g_lane
         always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
               memDataOen[b*LANE_W +: LANE_W] <= '1;
            end else begin
               // drive from setup until one cycle past write end
               memDataOen[b*LANE_W +: LANE_W] <=
                  {LANE_W{!((state_q == ST_WSETUP ||
                             state_q == ST_WRITE ||
                             state_q == ST_WEND) && lanes_q[b])}};
            end
         end
      end
   endgenerate

   // ==========================================================
   // ready and read answer
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         reqReady <= 1'b0;
         rspValid <= 1'b0;
         rsp      <= '0;
      end else begin
         reqReady <= (state_q == ST_REL && cnt_q == CNT_W'(TURN_CYC - 1))
                     || (state_q == ST_POWER
                         && cnt_q == CNT_W'(POWER_WAIT - 1))
                     || (state_q == ST_IDLE && !reqValid);
         rspValid <= 1'b0;
         if (state_q == ST_READ && cnt_q == CNT_W'(READ_CYC + 2)) begin
            rspValid      <= 1'b1;
            rsp.rdata     <= dataSync; // corrected word
            rsp.corrected <= errSync;
         end
      end
   end
endmodule
`default_nettype wire

// ---- hw/eas_pkg.sv ----
`default_nettype none
package eas_pkg;
   // ==========================================================
   // geometry
   localparam int ADDR_W     = 20;
   localparam int DATA_W     = 16;
   localparam int LANES      = 2;
   localparam int LANE_W     = 8;
   // ==========================================================
   // timing in ps or us as named, and clock period
   localparam int CLK_PERIOD_PS = 5000;
   localparam int SUPPLY_TO_FIRST_ACCESS_US = 100;
   localparam int ADDRESS_ACCESS_TIME_PS    = 15000;
   localparam int OUTPUT_HOLD_AFTER_ADDRESS_PS = 3000;
   localparam int DRIVE_ENABLE_ACCESS_TIME_PS  = 8000;
   localparam int SELECT_ACCESS_TIME_PS     = 15000;
   localparam int BYTE_SELECT_ACCESS_TIME_PS = 8000;
   localparam int BYTE_RELEASE_FLOAT_TIME_PS = 8000;
   localparam int DESELECT_TO_STANDBY_PS    = 15000;
   localparam int ADDRESS_TO_WRITE_END_PS   = 12000;
   localparam int DATA_SETUP_TO_WRITE_END_PS = 8000;
   localparam int BYTE_SELECT_TO_WRITE_END_PS = 12000;
   localparam int WRITE_STROBE_FLOAT_TIME_PS = 8000;
   // ==========================================================
   // derived cycle counts: least times round up
   localparam int POWER_CYC =
      (SUPPLY_TO_FIRST_ACCESS_US * 1000000 + CLK_PERIOD_PS - 1)
      / CLK_PERIOD_PS;
   localparam int READ_CYC =
      (SELECT_ACCESS_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WRITE_CYC =
      (BYTE_SELECT_TO_WRITE_END_PS + WRITE_STROBE_FLOAT_TIME_PS
       + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int DSETUP_CYC =
      (DATA_SETUP_TO_WRITE_END_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TURN_CYC =
      (BYTE_RELEASE_FLOAT_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 16;
   // ==========================================================
   // user request carrier
   typedef struct packed {
      logic              write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [LANES-1:0]  lanes;
   } eas_req_s;
   typedef struct packed {
      logic [DATA_W-1:0] rdata;
      logic              corrected;
   } eas_rsp_s;
endpackage
`default_nettype wire

// ---- hw/eas_sync.sv ----
`default_nettype none
module eas_sync
   import eas_pkg::*;
#(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rstn,
   // level in and out
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);
   logic [W-1:0] meta_q;
   // ==========================================================
   // two stage synchroniser, per bit
   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
               meta_q[i]  <= 1'b0;
               syncOut[i] <= 1'b0;
            end else begin
               meta_q[i]  <= asyncIn[i];
               syncOut[i] <= meta_q[i];
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

// ---- sim/eas_host_monitor.sv ----
`default_nettype none
// ==========================================
// pin-level checks of the memory host port
module eas_host_monitor
   import eas_pkg::*;
#(
   parameter int POWER_WAIT = POWER_CYC
) (
   // clock and reset
   input wire logic              sys_clk,
   input wire logic              rstn,
   // user side
   input wire logic              reqReady,
   input wire logic              rspValid,
   // memory pins
   input wire logic [ADDR_W-1:0] memAddr,
   input wire logic              select_low_active,
   input wire logic              select_high_active,
   input wire logic              memOeN,
   input wire logic              memWeN,
   input wire logic              upper_byte_sel_n,
   input wire logic              lower_byte_sel_n,
   input wire logic [DATA_W-1:0] memDataOut,
   input wire logic [DATA_W-1:0] memDataOen
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   logic              sel;
   logic [DATA_W-1:0] laneOff;
   logic [CNT_W-1:0]  upCnt_q;
   // combined select and per-bit lane mask
   assign sel     = !select_low_active && select_high_active;
   assign laneOff = {{LANE_W{upper_byte_sel_n}}, {LANE_W{lower_byte_sel_n}}};
   // cycles since reset release, saturating
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) upCnt_q <= '0;
      else if (upCnt_q < POWER_WAIT) upCnt_q <= upCnt_q + 1'b1;
   end
   pwr_wait_a: assert property (
      reqReady |-> upCnt_q >= POWER_WAIT - 1) else $error("early ready");
   read_quiet_a: assert property (
      !memOeN |-> memWeN && &memDataOen) else $error("drive in read");
   write_gate_a: assert property (
      !memWeN |-> sel && !(upper_byte_sel_n && lower_byte_sel_n))
      else $error("write without select");
   write_len_a: assert property (
      $fell(memWeN) |-> !memWeN [*4] ##1 (memWeN && !sel))
      else $error("strobe length");
   addr_hold_a: assert property (
      (!memWeN || $rose(memWeN)) |-> $stable(memAddr))
      else $error("address moved in write");
   data_setup_a: assert property (
      !memWeN |-> (memDataOen & ~laneOff) == '0 && $stable(memDataOut))
      else $error("write data not driven");
   data_end_a: assert property (
      $rose(memWeN) |-> $stable(memDataOut) && $stable(memDataOen))
      else $error("data dropped at write end");
   turn_free_a: assert property (
      $rose(memOeN) |-> (&memDataOen) [*3]) else $error("turnaround");
   read_time_a: assert property (
      $fell(memOeN) |-> sel && $stable(memAddr) ##5 rspValid)
      else $error("read timing");
   cover property ($fell(memWeN));
   cover property ($fell(memOeN));
   cover property (rspValid);
endmodule
bind eas_host eas_host_monitor #(
   .POWER_WAIT (POWER_WAIT)
) eas_host_monitor_inst (
   .sys_clk            (sys_clk),
   .rstn               (rstn),
   .reqReady           (reqReady),
   .rspValid           (rspValid),
   .memAddr            (memAddr),
   .select_low_active  (select_low_active),
   .select_high_active (select_high_active),
   .memOeN             (memOeN),
   .memWeN             (memWeN),
   .upper_byte_sel_n   (upper_byte_sel_n),
   .lower_byte_sel_n   (lower_byte_sel_n),
   .memDataOut         (memDataOut),
   .memDataOen         (memDataOen)
);
`default_nettype wire

// ---- sim/eas_sram_model.sv ----
`default_nettype none
// ==========================================
// behavioural memory on the far side of the port
module eas_sram_model
   import eas_pkg::*;
#(
   parameter int ACC = 8
) (
   // address and controls
   input  wire logic [ADDR_W-1:0] memAddr,
   input  wire logic              select_low_active,
   input  wire logic              select_high_active,
   input  wire logic              memOeN,
   input  wire logic              memWeN,
   input  wire logic              upper_byte_sel_n,
   input  wire logic              lower_byte_sel_n,
   // data and error lines
   input  wire logic [DATA_W-1:0] memDataIn,
   input  wire logic              injErr,
   output logic      [DATA_W-1:0] dq,
   output logic      [DATA_W-1:0] drvMask,
   output logic                   memErrIn
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [DATA_W-1:0] mem [256];
   logic [DATA_W-1:0] hold;
   logic              sel;
   logic              rd;
   // select decode and read gating
   assign sel = !select_low_active && select_high_active;
   assign rd  = sel && !memOeN && memWeN;
   assign drvMask = {{LANE_W{rd && !upper_byte_sel_n}},
                     {LANE_W{rd && !lower_byte_sel_n}}};
   // released lanes show the inverse of the last word
   always @* if (rd) hold = mem[memAddr[7:0]];
   assign #ACC dq = (drvMask & mem[memAddr[7:0]])
                  | (~drvMask & ~hold);
   assign #ACC memErrIn = rd ? injErr : !injErr;
   // store lanes while strobe, select and lane overlap
   always @* begin
      if (sel && !memWeN && !lower_byte_sel_n)
         mem[memAddr[7:0]][7:0] = memDataIn[7:0];
      if (sel && !memWeN && !upper_byte_sel_n)
         mem[memAddr[7:0]][15:8] = memDataIn[15:8];
   end
endmodule
`default_nettype wire

// ---- sim/ecc_async_sram_port_tb.sv ----
`default_nettype none
// ==========================================
// self-checking bench for the memory host port
module ecc_async_sram_port_tb
   import eas_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic              sys_clk = 1'b0;
   logic              rstn = 1'b0;
   logic              reqValid = 1'b0;
   logic              injErr = 1'b0;
   eas_req_s          req = '0;
   eas_rsp_s          rsp, got;
   logic              reqReady, rspValid, memOeN, memWeN, memErrIn;
   logic              select_low_active, select_high_active;
   logic              upper_byte_sel_n, lower_byte_sel_n;
   logic [ADDR_W-1:0] memAddr;
   logic [DATA_W-1:0] memDataOut, memDataOen, memDataIn, dq, drvMask;
   int                lat, cyc = 0, bad_count = 0, n_compared = 0;
   // device, memory and resolved data bus
   eas_host #(
      .POWER_WAIT (4)
   ) eas_host_inst (
      .sys_clk            (sys_clk),
      .rstn               (rstn),
      .reqValid           (reqValid),
      .req                (req),
      .reqReady           (reqReady),
      .rspValid           (rspValid),
      .rsp                (rsp),
      .memAddr            (memAddr),
      .select_low_active  (select_low_active),
      .select_high_active (select_high_active),
      .memOeN             (memOeN),
      .memWeN             (memWeN),
      .upper_byte_sel_n   (upper_byte_sel_n),
      .lower_byte_sel_n   (lower_byte_sel_n),
      .memDataIn          (memDataIn),
      .memDataOut         (memDataOut),
      .memDataOen         (memDataOen),
      .memErrIn           (memErrIn)
   );
   eas_sram_model eas_sram_model_inst (
      .memAddr            (memAddr),
      .select_low_active  (select_low_active),
      .select_high_active (select_high_active),
      .memOeN             (memOeN),
      .memWeN             (memWeN),
      .upper_byte_sel_n   (upper_byte_sel_n),
      .lower_byte_sel_n   (lower_byte_sel_n),
      .memDataIn          (memDataIn),
      .injErr             (injErr),
      .dq                 (dq),
      .drvMask            (drvMask),
      .memErrIn           (memErrIn)
   );
   assign memDataIn = (~memDataOen & memDataOut) | (memDataOen & dq);
   always #2.5 sys_clk = ~sys_clk;
   // hang guard and bus contention watch
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         bad_count++;
         end_sim();
      end
   end
   always @(negedge sys_clk) begin
      if (rstn && |(~memDataOen & drvMask))
         chk(1, 0);
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("ERROR %0t saw %h expected %h", $time, g, e);
      end
   endtask
   task automatic end_sim();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // one request; reads wait for the answer and count cycles
   task automatic op(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d, input logic [1:0] l);
      int n;
      n = 0;
      lat = 0;
      @(posedge sys_clk) #1;
      reqValid = 1'b1;
      req = '{w, a, d, l};
      do @(negedge sys_clk); while (reqReady !== 1'b1 && ++n < 99);
      @(posedge sys_clk) #1;
      reqValid = 1'b0;
      while (!w && lat < 99 && rspValid !== 1'b1) begin
         @(posedge sys_clk);
         lat++;
         @(negedge sys_clk);
      end
      got = rsp;
   endtask
   // full word written then read straight after
   task automatic t_full();
      op(1'b1, 20'hF00A3, 16'hA55A, 2'h3);
      op(1'b0, 20'hF00A3, 16'h0000, 2'h3);
      chk(got.rdata, 16'hA55A);
      chk(got.corrected, 1'h0);
      chk(lat, READ_CYC + 3);
   endtask
   // byte writes merge into one word
   task automatic t_bytes();
      op(1'b1, 20'h00005, 16'h1234, 2'h3);
      op(1'b1, 20'h00005, 16'hFFCD, 2'h1);
      op(1'b1, 20'h00005, 16'hAB00, 2'h2);
      op(1'b0, 20'h00005, 16'h0000, 2'h3);
      chk(got.rdata, 16'hABCD);
   endtask
   // corrected single-bit error is flagged
   task automatic t_err();
      injErr = 1'b1;
      op(1'b0, 20'h00005, 16'h0000, 2'h3);
      injErr = 1'b0;
      chk(got.corrected, 1'h1);
      chk(got.rdata, 16'hABCD);
   endtask
   // single-lane reads
   task automatic t_lane();
      op(1'b0, 20'h00005, 16'h0000, 2'h1);
      chk(got.rdata[7:0], 8'hCD);
      op(1'b0, 20'h00005, 16'h0000, 2'h2);
      chk(got.rdata[15:8], 8'hAB);
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      #1 rstn = 1'b1;
      t_full();
      t_bytes();
      t_err();
      t_lane();
      end_sim();
   end
endmodule
`default_nettype wire
